// ==== rtl/fpdr_routing.sv ====
// fpdr_routing: operand and result routing for the fp mac datapath
`timescale 1ns/1ps
module fpdr_routing
  import fpdr_pkg::*;
#(
  parameter int unsigned DATA_W = FPDR_DATA_W
)
(
  input wire logic clock, // 50 MHz
  input wire logic rstn, // sync reset, low
  input wire fpdr_instr_s instr, // microword from sequencer
  input wire logic [31:0] a_port_data, // register file a read
  input wire logic [31:0] b_port_data, // register file b read
  input wire logic [31:0] y_port_reg, // y port input register
  input wire logic [31:0] x_port_in, // x port input data
  input wire logic [31:0] mult_result, // multiplier output
  input wire logic [31:0] alu_result_bus, // alu output
  input wire logic result_not_positive_flag, // alu result <= 0
  input wire logic result_zero_flag, // alu result == 0
  input wire logic z_port_drive_enable_n, // pin, low drives z
  output logic [31:0] mult_a_in, // multiplier first operand
  output logic [31:0] mult_b_in, // multiplier second operand
  output logic [31:0] alu_first_operand, // alu a operand
  output logic [31:0] alu_b_in, // alu b operand
  output logic [31:0] c_bus, // c bus value
  output logic [4:0] rf_write_addr, // delayed c address
  output logic rf_write_en, // register file c write
  output logic x_to_rf_en, // x port load to d port
  output logic x_store_en, // store register to x port
  output logic [31:0] z_port_out, // z port data
  output logic z_port_oe, // z port drive enable
  output logic cond_reg, // condition register
  output logic zero_reg, // zero register
  output logic [12:0] mode_reg, // mode register
  output fpdr_misc_e misc_op // decoded misc op in flight
);

  // ==========================================================
  // parameter check
  if (DATA_W != FPDR_DATA_W)
  begin : g_bad_width
    $error("fpdr_routing serves only 32-bit words");
  end

  // ==========================================================
  // helpers
  // reciprocal seed: 1/1.f lies in (0.5,1], so the exponent drops
  // one extra step unless f is zero; inverted top fraction bits
  // give a linear seed good to about three bits
  function automatic logic [31:0] recip_seed(input fpdr_float_s v);
    fpdr_float_s s;
    s = '0;
    s.sign = v.sign;
    if (v.frac == '0)
    begin
      s.exp = FPDR_RECIP_EXP_EXACT - v.exp;
    end
    else
    begin
      s.exp = FPDR_RECIP_EXP_BASE - v.exp;
      s.frac[22:16] = ~v.frac[22:16];
    end
    return s;
  endfunction

  // misc operation selected by the b address when function is zero
  function automatic fpdr_misc_e misc_decode(input fpdr_instr_s i);
    fpdr_misc_e m;
    m = FPDR_OP_NONE;
    if (i.func == FPDR_FN_MISC)
    begin
      unique case (i.b_addr)
        FPDR_MISC_CLR_STAT: m = FPDR_OP_CLR_STAT;
        FPDR_MISC_RD_STAT: m = FPDR_OP_RD_STAT;
        FPDR_MISC_LOAD_MODE: m = FPDR_OP_LOAD_MODE;
        FPDR_MISC_ABS: m = FPDR_OP_ABS;
        FPDR_MISC_FLOAT: m = FPDR_OP_FLOAT;
        FPDR_MISC_FIX: m = FPDR_OP_FIX;
        FPDR_MISC_LUT: m = FPDR_OP_LUT;
        default: m = FPDR_OP_NONE; // reserved codes
      endcase
    end
    return m;
  endfunction

  // mac type ops carry func msb set
  function automatic logic is_mac(input fpdr_instr_s i);
    return i.func[2];
  endfunction

  fpdr_state_s st_ff;
  fpdr_state_s nxt_st;
  logic [31:0] b_bus;

  // ==========================================================
  // operand stage: b bus and multiplier inputs from current word
  always_comb
  begin
    b_bus = st_ff.ir.b_src_y ? y_port_reg : b_port_data;
  end

  // ==========================================================
  // next-state logic
  always_comb
  begin
    nxt_st = st_ff;
    // instruction pipeline, one stage per cycle
    nxt_st.ir = instr;
    nxt_st.p1 = st_ff.ir;
    nxt_st.p2 = st_ff.p1;
    nxt_st.a_dly1 = a_port_data;
    nxt_st.a_dly2 = st_ff.a_dly1;
    nxt_st.b_dly1 = b_bus;
    nxt_st.misc = misc_decode(st_ff.ir);

    // multiplier inputs, first cycle of the op
    nxt_st.mult_a = a_port_data;
    if (st_ff.mode[FPDR_MODE_MATCH_BIT]
        && st_ff.ir.c_addr == st_ff.ir.b_addr)
    begin
      nxt_st.mult_b = st_ff.c_bus;
    end
    else
    begin
      nxt_st.mult_b = st_ff.ir.mult_b_from_c ? st_ff.c_bus : b_bus;
    end

    // alu inputs, second cycle of the op
    nxt_st.alu_first_operand = is_mac(st_ff.p1) ? mult_result
                                                 : st_ff.a_dly1;
    unique case (st_ff.p1.alu_b_sel)
      FPDR_ABS_ZERO: nxt_st.alu_b = FPDR_CONST_ZERO;
      FPDR_ABS_TWO: nxt_st.alu_b = FPDR_CONST_TWO;
      FPDR_ABS_T3: nxt_st.alu_b = st_ff.temp_register3;
      FPDR_ABS_T1: nxt_st.alu_b = st_ff.temp_register1;
      FPDR_ABS_T2: nxt_st.alu_b = st_ff.temp_register2;
      FPDR_ABS_BBUS: nxt_st.alu_b = st_ff.b_dly1;
      FPDR_ABS_CBUS: nxt_st.alu_b = st_ff.c_bus;
      default: nxt_st.alu_b = FPDR_CONST_ZERO; // reserved reads zero
    endcase

    // result stage: c bus source, lookup beats x port beats alu
    if (misc_decode(st_ff.p2) == FPDR_OP_LUT)
    begin
      nxt_st.c_bus = recip_seed(st_ff.a_dly2);
    end
    else if (st_ff.ir.io_ctl == FPDR_IO_LOAD_CBUS)
    begin
      nxt_st.c_bus = x_port_in;
    end
    else
    begin
      nxt_st.c_bus = alu_result_bus;
    end

    // temp register destination of the finishing op
    if (!(st_ff.p2.func == FPDR_FN_MISC))
    begin
      unique case (st_ff.p2.alu_dst)
        FPDR_DST_T1: nxt_st.temp_register1 = alu_result_bus;
        FPDR_DST_T2: nxt_st.temp_register2 = alu_result_bus;
        FPDR_DST_T3: nxt_st.temp_register3 = alu_result_bus;
        FPDR_DST_CBUS: nxt_st.temp_register1 = st_ff.temp_register1;
      endcase
    end

    // write port: address delayed three stages, enable active low
    nxt_st.wr_addr = st_ff.p2.c_addr;
    nxt_st.wr_en = !st_ff.p2.c_write_enable_n;

    // flags only move when the op asked for them
    if (st_ff.p2.condition_update_enable)
    begin
      nxt_st.cond = result_not_positive_flag;
      nxt_st.zero = result_zero_flag;
    end

    // mode load acts at once; the sequencer keeps the pipe idle
    if (misc_decode(st_ff.ir) == FPDR_OP_LOAD_MODE)
    begin
      nxt_st.mode = {st_ff.ir.alu_b_sel, st_ff.ir.c_addr,
                     st_ff.ir.a_addr};
    end

    // z port enable pin passes two flops before use
    nxt_st.oez_sync = {st_ff.oez_sync[0], z_port_drive_enable_n};
    nxt_st.z_oe = !st_ff.oez_sync[1];
    nxt_st.z_out = alu_result_bus;
  end

  // ==========================================================
  // state register
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      st_ff <= '0;
      st_ff.mode <= FPDR_MODE_RST;
      st_ff.oez_sync <= 2'h3;
      st_ff.ir.c_write_enable_n <= 1'b1;
      st_ff.p1.c_write_enable_n <= 1'b1;
      st_ff.p2.c_write_enable_n <= 1'b1;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // outputs straight from the state register
  assign mult_a_in = st_ff.mult_a;
  assign mult_b_in = st_ff.mult_b;
  assign alu_first_operand = st_ff.alu_first_operand;
  assign alu_b_in = st_ff.alu_b;
  assign c_bus = st_ff.c_bus;
  assign rf_write_addr = st_ff.wr_addr;
  assign rf_write_en = st_ff.wr_en;
  // x direction decode on the registered word
  assign x_to_rf_en = st_ff.ir.io_ctl[0];
  assign x_store_en = (st_ff.ir.io_ctl == FPDR_IO_STORE);
  assign z_port_out = st_ff.z_out;
  assign z_port_oe = st_ff.z_oe;
  assign cond_reg = st_ff.cond;
  assign zero_reg = st_ff.zero;
  assign mode_reg = st_ff.mode;
  assign misc_op = st_ff.misc;

endmodule

// ==== rtl/fpdr_pkg.sv ====
// fpdr_pkg: shared types and constants for the fp datapath operand routing
package fpdr_pkg;

  // ==========================================================
  // word format and widths
  localparam int unsigned FPDR_DATA_W = 32;
  localparam int unsigned FPDR_SIGN_BIT = 31;
  localparam int unsigned FPDR_EXP_LSB = 23;
  localparam int unsigned FPDR_EXP_W = 8;
  localparam int unsigned FPDR_FRAC_W = 23;
  localparam int unsigned FPDR_SEED_W = 7;
  localparam int unsigned FPDR_MODE_W = 13;
  localparam int unsigned FPDR_MODE_MATCH_BIT = 11;
  localparam int unsigned FPDR_C_ADDR_DELAY = 3;

  // ==========================================================
  // constants and reset values
  localparam logic [31:0] FPDR_CONST_ZERO = 32'h0000_0000;
  localparam logic [31:0] FPDR_CONST_TWO = 32'h4000_0000;
  localparam logic [7:0] FPDR_RECIP_EXP_BASE = 8'hfd;
  localparam logic [7:0] FPDR_RECIP_EXP_EXACT = 8'hfe;
  localparam logic [12:0] FPDR_MODE_RST = 13'h0000;

  // ==========================================================
  // instruction field encodings
  localparam logic [2:0] FPDR_FN_MISC = 3'h0;
  localparam logic [4:0] FPDR_MISC_CLR_STAT = 5'h00;
  localparam logic [4:0] FPDR_MISC_RD_STAT = 5'h01;
  localparam logic [4:0] FPDR_MISC_LOAD_MODE = 5'h03;
  localparam logic [4:0] FPDR_MISC_ABS = 5'h04;
  localparam logic [4:0] FPDR_MISC_FLOAT = 5'h05;
  localparam logic [4:0] FPDR_MISC_FIX = 5'h06;
  localparam logic [4:0] FPDR_MISC_LUT = 5'h07;
  localparam logic [2:0] FPDR_ABS_ZERO = 3'h7;
  localparam logic [2:0] FPDR_ABS_TWO = 3'h6;
  localparam logic [2:0] FPDR_ABS_T3 = 3'h4;
  localparam logic [2:0] FPDR_ABS_T1 = 3'h3;
  localparam logic [2:0] FPDR_ABS_T2 = 3'h2;
  localparam logic [2:0] FPDR_ABS_BBUS = 3'h1;
  localparam logic [2:0] FPDR_ABS_CBUS = 3'h0;
  localparam logic [1:0] FPDR_DST_CBUS = 2'h3;
  localparam logic [1:0] FPDR_DST_T1 = 2'h2;
  localparam logic [1:0] FPDR_DST_T2 = 2'h1;
  localparam logic [1:0] FPDR_DST_T3 = 2'h0;
  localparam logic [1:0] FPDR_IO_LOAD = 2'h3;
  localparam logic [1:0] FPDR_IO_STORE = 2'h2;
  localparam logic [1:0] FPDR_IO_LOAD_CBUS = 2'h1;
  localparam logic [1:0] FPDR_IO_NOP = 2'h0;

  // ==========================================================
  // decoded miscellaneous operation
  typedef enum logic [2:0] {
    FPDR_OP_NONE = 3'h0,
    FPDR_OP_CLR_STAT = 3'h1,
    FPDR_OP_RD_STAT = 3'h3,
    FPDR_OP_LOAD_MODE = 3'h2,
    FPDR_OP_ABS = 3'h6,
    FPDR_OP_FLOAT = 3'h7,
    FPDR_OP_FIX = 3'h5,
    FPDR_OP_LUT = 3'h4
  } fpdr_misc_e;

  // 34-bit microword, msb first
  typedef struct packed {
    logic b_src_y;
    logic [2:0] func;
    logic [4:0] a_addr;
    logic [4:0] b_addr;
    logic [4:0] c_addr;
    logic c_write_enable_n;
    logic [1:0] io_ctl;
    logic [4:0] d_addr;
    logic [2:0] alu_b_sel;
    logic [1:0] alu_dst;
    logic mult_b_from_c;
    logic condition_update_enable;
  } fpdr_instr_s;

  // single-precision word
  typedef struct packed {
    logic sign;
    logic [7:0] exp;
    logic [22:0] frac;
  } fpdr_float_s;

  // whole state of the routing block
  typedef struct packed {
    fpdr_instr_s ir;
    fpdr_instr_s p1;
    fpdr_instr_s p2;
    logic [31:0] a_dly1;
    logic [31:0] a_dly2;
    logic [31:0] b_dly1;
    logic [31:0] mult_a;
    logic [31:0] mult_b;
    logic [31:0] alu_first_operand;
    logic [31:0] alu_b;
    logic [31:0] c_bus;
    logic [31:0] temp_register1;
    logic [31:0] temp_register2;
    logic [31:0] temp_register3;
    logic [31:0] z_out;
    logic [4:0] wr_addr;
    logic wr_en;
    logic cond;
    logic zero;
    logic [12:0] mode;
    logic [1:0] oez_sync;
    logic z_oe;
    fpdr_misc_e misc;
  } fpdr_state_s;

endpackage

// ==== testbench/fpdr_routing_asserts.sv ====
// timing relations watched at the routing block ports
`timescale 1ns/1ps
module fpdr_routing_asserts
  import fpdr_pkg::*;
(
  input wire logic clock, rstn, z_port_drive_enable_n, // clock, pins
  input wire fpdr_instr_s instr, // microword
  input wire logic [31:0] a_port_data, b_port_data, y_port_reg, // buses
  input wire logic [31:0] x_port_in, mult_result, alu_result_bus, // data
  input wire logic result_not_positive_flag, result_zero_flag, // flags
  input wire logic [31:0] mult_a_in, mult_b_in, alu_first_operand, // outs
  input wire logic [31:0] alu_b_in, c_bus, z_port_out, // outs
  input wire logic [4:0] rf_write_addr, // write address
  input wire logic rf_write_en, x_to_rf_en, x_store_en, z_port_oe, // ctl
  input wire logic cond_reg, zero_reg, // condition state
  input wire logic [12:0] mode_reg // mode
);
  // ==========================================================
  // helpers: edges since reset, words of earlier edges
  logic [2:0] run_ff;
  fpdr_instr_s w1_ff, w2_ff, w3_ff, w4_ff;
  logic lut4;
  always_ff @(posedge clock)
  begin
    run_ff <= !rstn ? 3'h0 : run_ff + {2'h0, run_ff != 3'h7};
    w1_ff <= instr;
    w2_ff <= w1_ff;
    w3_ff <= w2_ff;
    w4_ff <= w3_ff;
  end
  // a lookup three stages back owns the c bus
  assign lut4 = w4_ff.func == FPDR_FN_MISC && w4_ff.b_addr == FPDR_MISC_LUT;
  default clocking dcb @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence s_pin_low;
    !z_port_drive_enable_n [*4];
  endsequence
  sequence s_pin_high;
    z_port_drive_enable_n [*4];
  endsequence
  // ==========================================================
  // properties
  AST_MULT_A: assert property (run_ff > 3'h0 && $stable(a_port_data)
    |=> mult_a_in == $past(a_port_data)) else $error("mult a wrong");
  AST_MULT_B: assert property (run_ff > 3'h2 |-> mult_b_in ==
    ((($past(mode_reg[11]) && w2_ff.c_addr == w2_ff.b_addr)
    || w2_ff.mult_b_from_c) ? $past(c_bus) : w2_ff.b_src_y ?
    $past(y_port_reg) : $past(b_port_data))) else $error("mult b wrong");
  AST_ALU_A: assert property (run_ff > 3'h3 && w3_ff.func[2]
    |-> alu_first_operand == $past(mult_result)) else $error("alu a wrong");
  AST_ALU_B: assert property (run_ff > 3'h3
    && w3_ff.alu_b_sel > 3'h4
    && w3_ff.func != FPDR_FN_MISC |-> alu_b_in == (w3_ff.alu_b_sel ==
    FPDR_ABS_TWO ? FPDR_CONST_TWO : FPDR_CONST_ZERO)) else $error("alu b");
  AST_C_BUS: assert property (run_ff > 3'h4 && !lut4 |-> c_bus ==
    (w2_ff.io_ctl == FPDR_IO_LOAD_CBUS ? $past(x_port_in) :
    $past(alu_result_bus))) else $error("c bus source wrong");
  AST_WRITE: assert property (run_ff > 3'h4 |-> rf_write_addr ==
    w4_ff.c_addr && rf_write_en == !w4_ff.c_write_enable_n)
    else $error("register write wrong");
  AST_COND: assert property (run_ff > 3'h4 |->
    (w4_ff.condition_update_enable ? cond_reg ==
    $past(result_not_positive_flag) && zero_reg == $past(result_zero_flag)
    : $stable(cond_reg) && $stable(zero_reg))) else $error("flags wrong");
  AST_MODE: assert property (run_ff > 3'h2
    && w2_ff.func == FPDR_FN_MISC
    && w2_ff.b_addr == FPDR_MISC_LOAD_MODE |-> mode_reg == {w2_ff.alu_b_sel,
    w2_ff.c_addr, w2_ff.a_addr}) else $error("mode load wrong");
  AST_X_DIR: assert property (run_ff > 3'h0 |-> x_to_rf_en ==
    w1_ff.io_ctl[0] && x_store_en == (w1_ff.io_ctl == FPDR_IO_STORE))
    else $error("x port direction wrong");
  AST_Z_ON: assert property (s_pin_low |=> z_port_oe)
    else $error("z port not driven");
  AST_Z_OFF: assert property (s_pin_high |=> !z_port_oe)
    else $error("z port driven");
  AST_Z_DATA: assert property (run_ff > 3'h0 && z_port_oe
    |-> z_port_out == $past(alu_result_bus)) else $error("z data wrong");
endmodule

// ==== testbench/fpdr_seq_model.sv ====
// microcode sequencer model: one word per rising edge
`timescale 1ns/1ps
module fpdr_seq_model
  import fpdr_pkg::*;
(
  input wire logic clock, // rising edge
  input wire logic issue, // high sends word, low sends no-op
  input wire fpdr_instr_s word, // word to send
  output fpdr_instr_s instr // microword to the block
);
  // ==========================================================
  // no-op: add zero, kept off registers and flags
  function automatic fpdr_instr_s nop_word();
    fpdr_instr_s w;
    w = '0;
    w.func = 3'h3;
    w.c_write_enable_n = 1'b1;
    w.alu_b_sel = FPDR_ABS_ZERO;
    w.alu_dst = FPDR_DST_CBUS;
    return w;
  endfunction
  initial instr = nop_word();
  // idle slots carry no-ops, so a mode load stands alone
  always @(posedge clock)
    instr <= #1 (issue ? word : nop_word());
endmodule

// ==== testbench/tb_fpdr_routing.sv ====
// self-checking bench for the operand routing block
`timescale 1ns/1ps
module tb_fpdr_routing
  import fpdr_pkg::*;
;
  logic clock, rstn, issue, result_not_positive_flag, result_zero_flag;
  logic z_port_drive_enable_n, rf_write_en, x_to_rf_en, x_store_en;
  logic z_port_oe, cond_reg, zero_reg;
  fpdr_instr_s word, instr;
  fpdr_instr_s rows [8];
  logic [31:0] a_port_data, b_port_data, y_port_reg, x_port_in, mult_result;
  logic [31:0] alu_result_bus, mult_a_in, mult_b_in, alu_first_operand;
  logic [31:0] alu_b_in, c_bus, z_port_out, ec, bb, eb;
  logic [31:0] tr [1:3];
  logic [4:0] rf_write_addr;
  logic [12:0] mode_reg;
  fpdr_misc_e misc_op;
  int errors, checks, r;
  fpdr_routing fpdr_routing_inst (.clock, .rstn, .instr, .a_port_data,
    .b_port_data, .y_port_reg, .x_port_in, .mult_result, .alu_result_bus,
    .result_not_positive_flag, .result_zero_flag, .z_port_drive_enable_n,
    .mult_a_in, .mult_b_in, .alu_first_operand, .alu_b_in, .c_bus,
    .rf_write_addr, .rf_write_en, .x_to_rf_en, .x_store_en, .z_port_out,
    .z_port_oe, .cond_reg, .zero_reg, .mode_reg, .misc_op);
  fpdr_seq_model fpdr_seq_model_inst (.clock, .issue, .word, .instr);
  // ==========================================================
  // clock and shared tasks
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic cmp_data(input logic [31:0] got, exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, exp);
    cmp_data({31'h0, got}, {31'h0, exp});
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // word maker; c address follows the alu b select for variety
  function automatic fpdr_instr_s mk(logic [2:0] f, s, logic [1:0] d, io,
    logic y, m);
    return {y, f, 5'h00, 5'h1e, {2'h0, s}, m, io, 5'h00, s, d, m, 1'b0};
  endfunction
  // ==========================================================
  // main sequence
  initial
  begin
    rstn = 1'b0;
    issue = 1'b0;
    word = '0;
    {result_not_positive_flag, result_zero_flag} = 2'h0;
    z_port_drive_enable_n = 1'b0;
    a_port_data = 32'h3fc0_0000;
    b_port_data = 32'h4080_0000;
    y_port_reg = 32'h40a0_0000;
    x_port_in = 32'h40c0_0000;
    mult_result = 32'h4200_0000;
    alu_result_bus = 32'h4100_0000;
    rows = '{mk(3'h7, 3'h7, 2'h3, 2'h0, 1, 0),
      mk(3'h3, 3'h6, 2'h2, 2'h0, 1, 0),
      mk(3'h7, 3'h3, 2'h1, 2'h1, 0, 1), mk(3'h3, 3'h2, 2'h0, 2'h2, 0, 0),
      mk(3'h7, 3'h4, 2'h3, 2'h3, 1, 0), mk(3'h3, 3'h1, 2'h3, 2'h0, 1, 1),
      mk(3'h3, 3'h0, 2'h3, 2'h0, 0, 0), mk(3'h3, 3'h5, 2'h3, 2'h0, 0, 0)};
    tick(16);
    rstn = 1'b1;
    issue = 1'b1;
    // each row repeats until every stage holds it
    for (r = 0; r < 8; r++)
    begin
      word = rows[r];
      // the previous row's ops still finish for four edges on the old bus
      tick(4);
      alu_result_bus = 32'h4100_0000 + 32'(r);
      tick(6);
      ec = word.io_ctl == FPDR_IO_LOAD_CBUS ? x_port_in : alu_result_bus;
      bb = word.b_src_y ? y_port_reg : b_port_data;
      case (word.alu_b_sel)
        3'h0: eb = ec;
        3'h1: eb = bb;
        3'h2: eb = tr[2];
        3'h3: eb = tr[1];
        3'h4: eb = tr[3];
        3'h6: eb = FPDR_CONST_TWO;
        default: eb = 32'h0000_0000;
      endcase
      cmp_data(mult_a_in, a_port_data);
      cmp_data(mult_b_in, word.mult_b_from_c ? ec : bb);
      cmp_data(alu_first_operand,
        word.func[2] ? mult_result : a_port_data);
      cmp_data(alu_b_in, eb);
      cmp_data(c_bus, ec);
      cmp_data(z_port_out, alu_result_bus);
      cmp_bit(z_port_oe, 1'b1);
      cmp_data({27'h0, rf_write_addr}, {27'h0, word.c_addr});
      cmp_bit(rf_write_en, !word.c_write_enable_n);
      cmp_bit(x_to_rf_en, word.io_ctl[0]);
      cmp_bit(x_store_en, word.io_ctl == FPDR_IO_STORE);
      if (word.alu_dst != FPDR_DST_CBUS)
        tr[3 - int'(word.alu_dst)] = alu_result_bus;
      $display("row %0d done", r);
    end
    // lookup beats an x port load onto the c bus
    word = mk(3'h0, 3'h7, 2'h3, 2'h1, 0, 0);
    word.b_addr = FPDR_MISC_LUT;
    tick(10);
    cmp_data(c_bus, 32'h3f3f_0000);
    cmp_data({29'h0, misc_op}, {29'h0, FPDR_OP_LUT});
    a_port_data = 32'h4000_0000;
    tick(10);
    cmp_data(c_bus, 32'h3f00_0000);
    $display("lookup test done");
    // mode load alone between no-ops, then address match forces c bus
    issue = 1'b0;
    tick(6);
    word.b_addr = FPDR_MISC_LOAD_MODE;
    word.a_addr = 5'h15;
    word.c_addr = 5'h0a;
    word.alu_b_sel = 3'h2;
    issue = 1'b1;
    tick(1);
    issue = 1'b0;
    tick(6);
    cmp_data({19'h0, mode_reg}, 32'h0000_0955);
    word = mk(3'h3, 3'h7, 2'h3, 2'h0, 0, 0);
    word.b_addr = 5'h07;
    issue = 1'b1;
    tick(10);
    cmp_data(mult_b_in, alu_result_bus);
    $display("mode test done");
    // flags follow only while enabled
    word.condition_update_enable = 1'b1;
    {result_not_positive_flag, result_zero_flag} = 2'h3;
    tick(10);
    cmp_bit(cond_reg, 1'b1);
    word.condition_update_enable = 1'b0;
    // enabled ops still in the pipe must see the old flags
    tick(4);
    {result_not_positive_flag, result_zero_flag} = 2'h0;
    tick(6);
    cmp_bit(cond_reg, 1'b1);
    cmp_bit(zero_reg, 1'b1);
    z_port_drive_enable_n = 1'b1;
    tick(6);
    cmp_bit(z_port_oe, 1'b0);
    $display("flag and z test done");
    // reset in mid-run clears mode and write strobe
    rstn = 1'b0;
    tick(3);
    cmp_data({19'h0, mode_reg}, 32'h0);
    cmp_bit(rf_write_en, 1'b0);
    cmp_bit(z_port_oe, 1'b0);
    $display("reset test done");
    end_sim();
  end
  // guard against a hung run
  initial
  begin
    #50000;
    errors++;
    end_sim();
  end
endmodule
bind fpdr_routing fpdr_routing_asserts fpdr_routing_asserts_inst (.clock,
  .rstn, .z_port_drive_enable_n, .instr, .a_port_data, .b_port_data,
  .y_port_reg, .x_port_in, .mult_result, .alu_result_bus,
  .result_not_positive_flag, .result_zero_flag, .mult_a_in, .mult_b_in,
  .alu_first_operand, .alu_b_in, .c_bus, .z_port_out, .rf_write_addr,
  .rf_write_en, .x_to_rf_en, .x_store_en, .z_port_oe, .cond_reg, .zero_reg,
  .mode_reg);
